/* File: sgc_adc_model.sv */
// Behavioural model of four chains of six 24-bit converters with slot-one data-ready.
// Assumes the bench loads each chain's 144 bits before it pulses start.
`timescale 1ns/1ps
module sgc_adc_model
  import sgc_pkg::*;
(
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          start,
  input  wire sgc_chain_t [`SGC_BUNDLES-1:0] load,
  output logic                               drdy_n,
  output logic [`SGC_BUNDLES-1:0]            miso
);
  int   pos;
  logic cs_seen;
  initial begin
    drdy_n  = 1'b1;
    miso    = 4'h5;
    pos     = 0;
    cs_seen = 1'b1;
  end
  // One process owns every line, so each has a single driver
  always @(posedge start or cs_n or negedge sclk) begin
    if (cs_n !== cs_seen) begin
      cs_seen = cs_n;
      pos     = 0;
      if (cs_n === 1'b1) begin
        // On release data-ready goes high and each MISO line shows the inverse of its last value
        drdy_n = 1'b1;
        miso   = ~miso;
      end
    end else if (start === 1'b1 && cs_n === 1'b1) begin
      // Slot one reports a finished conversion
      drdy_n = 1'b0;
    end else if (cs_n === 1'b0 && pos < `SGC_CHAIN_BITS) begin
      // Next bit, MSB first, on each falling serial clock
      for (int b = 0; b < `SGC_BUNDLES; b++) miso[b] = load[b][`SGC_CHAIN_BITS-1-pos];
      pos++;
    end
  end
endmodule // sgc_adc_model

/* File: sgc_fifo.sv */
// First-word-fall-through FIFO with registered output stage.
// Assumes one clock, synchronous active-high reset, clock enable.
`timescale 1ns/1ps
module sgc_fifo
  import sgc_pkg::*;
#(
  parameter int W     = `SGC_FIFO_W,
  parameter int DEPTH = `SGC_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
      $error("sgc_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW:0]  wptr;
    logic [AW:0]  rptr;
    logic         out_valid;
    logic [W-1:0] out_data;
  } fifo_st_t;

  fifo_st_t     st_reg;
  fifo_st_t     st_next;
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  count;
  logic         push;

  assign count    = st_reg.wptr - st_reg.rptr;
  assign wr_ready = (count != (AW+1)'(DEPTH));
  assign push     = ce && wr_valid && wr_ready;
  assign rd_valid = st_reg.out_valid;
  assign rd_data  = st_reg.out_data;

  always_comb begin
    st_next = st_reg;
    if (rst) begin
      st_next = '0;
    end else if (ce) begin
      if (push) begin
        st_next.wptr = st_reg.wptr + 1'b1;
      end
      if ((!st_reg.out_valid || rd_ready) && count != '0) begin
        st_next.out_data  = mem[st_reg.rptr[AW-1:0]];
        st_next.out_valid = 1'b1;
        st_next.rptr      = st_reg.rptr + 1'b1;
      end else if (rd_ready) begin
        st_next.out_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wptr[AW-1:0]] <= wr_data;
    end
  end
endmodule // sgc_fifo

/* File: sgc_map.svh */
// Constants for the sample gatherer: geometry, FIFO shape and link timing.
// Assumes inclusion by sgc_pkg only.
`ifndef SGC_MAP_SVH
`define SGC_MAP_SVH
`define SGC_BUNDLES        4
`define SGC_CHAIN          6
`define SGC_CHANS          24
`define SGC_SAMPLE_W       24
`define SGC_EXT_W          32
`define SGC_WORD_W         16
`define SGC_FIFO_W         17
`define SGC_FIFO_DEPTH     1024
`define SGC_CHAIN_BITS     144
`define SGC_SCLK_HALF      8
`define SGC_LINK_CLK_HZ    166666666
`define SGC_SAMPLE_RATE_HZ 25000
`define SGC_OVERHEAD_PCT   25
`define SGC_PCT_FULL       100
`endif

/* File: sgc_pkg.sv */
// Types shared by the sample gatherer, its converter model and its testbench.
// Assumes sgc_map.svh on the include path.
package sgc_pkg;
  `include "sgc_map.svh"

  typedef enum logic [2:0] {
    LNK_IDLE  = 3'b001,
    LNK_SHIFT = 3'b010,
    LNK_DONE  = 3'b100
  } sgc_lnk_state_t;

  typedef enum logic [2:0] {
    PK_IDLE = 3'b001,
    PK_HDR  = 3'b010,
    PK_WORD = 3'b100
  } sgc_pk_state_t;

  typedef logic [`SGC_CHAIN_BITS-1:0] sgc_chain_t;

  typedef struct packed {
    logic                    last;
    logic [`SGC_WORD_W-1:0]  data;
  } sgc_word_t;

  typedef struct packed {
    logic                          rst_s1;
    logic                          rst_s2;
    logic                          ce_s1;
    logic                          ce_s2;
    logic                          drdy_s1;
    logic                          drdy_s2;
    logic                          drdy_s3;
    logic [`SGC_BUNDLES-1:0]       miso_s1;
    logic [`SGC_BUNDLES-1:0]       miso_s2;
    logic                          ack_s1;
    logic                          ack_s2;
    sgc_lnk_state_t                state;
    logic [7:0]                    div;
    logic [7:0]                    bitcnt;
    logic                          sclk;
    logic                          cs_n;
    sgc_chain_t [`SGC_BUNDLES-1:0] shreg;
    sgc_chain_t [`SGC_BUNDLES-1:0] hold;
    logic                          req;
    logic                          overrun;
  } sgc_lnk_t;

  typedef struct packed {
    logic                   req_s1;
    logic                   req_s2;
    logic                   ack;
    sgc_pk_state_t          state;
    logic [`SGC_CHANS-1:0]  mask;
    logic [4:0]             idx;
    logic                   half;
    logic [`SGC_WORD_W-1:0] seq;
  } sgc_pk_t;
endpackage

/* File: sgc_sample_gatherer.sv */
// Sample gatherer: serial readout of four daisy chains, channel masking, packing into a FIFO.
// Assumes converters shift out MSB first on falling sclk; link_clk unrelated to ref_clk.
//
// What this block does
// - Read all four chains together, six samples
// - Sign-extend to 32 bits, emit two words
// - Only slot one data-ready starts a read
// - No data-ready means waiting forever
// - Serial clock fast enough for chained samples
// - Masked-off channels are dropped
// - Selected samples packed without CRC into FIFO
// - FIFO 17 by 1024, top bit ends set
`timescale 1ns/1ps
module sgc_sample_gatherer
  import sgc_pkg::*;
#(
  parameter int LINK_CLK_HZ = `SGC_LINK_CLK_HZ,
  parameter int SCLK_HALF   = `SGC_SCLK_HALF,
  parameter int FIFO_DEPTH  = `SGC_FIFO_DEPTH
) (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  input  wire logic                    link_clk,
  input  wire logic [`SGC_CHANS-1:0]   chan_mask,
  input  wire logic                    drdy_n,
  input  wire logic [`SGC_BUNDLES-1:0] miso,
  output logic                         sclk,
  output logic                         cs_n,
  output logic                         overrun,
  output logic [`SGC_FIFO_W-1:0]       pkt_data,
  output logic                         pkt_valid,
  input  wire logic                    pkt_ready
);
  localparam longint SCLK_HZ = longint'(LINK_CLK_HZ) / (2 * SCLK_HALF);
  localparam longint NEED_HZ = longint'(`SGC_CHAIN) * `SGC_SAMPLE_W * `SGC_SAMPLE_RATE_HZ
                               * (`SGC_PCT_FULL + `SGC_OVERHEAD_PCT) / `SGC_PCT_FULL;

  generate
    if (SCLK_HALF < 1 || SCLK_HALF > 255 || SCLK_HZ < NEED_HZ) begin : g_bad
      $error("sgc_sample_gatherer: serial clock too slow for the chain");
    end
  endgenerate

  sgc_lnk_t  lnk_reg;
  sgc_lnk_t  lnk_next;
  sgc_pk_t   pk_reg;
  sgc_pk_t   pk_next;
  sgc_word_t fifo_wr_data;
  logic      fifo_wr_valid;
  logic      fifo_wr_ready;
  logic      drdy_fall;

  logic [`SGC_SAMPLE_W-1:0] samp [`SGC_CHANS];
  logic [`SGC_EXT_W-1:0]    ext;
  logic [`SGC_CHANS-1:0]    rest;

  assign sclk    = lnk_reg.sclk;
  assign cs_n    = lnk_reg.cs_n;
  assign overrun = lnk_reg.overrun;

  assign drdy_fall = lnk_reg.drdy_s3 && !lnk_reg.drdy_s2;

  // Link side: chain readout
  always_comb begin
    lnk_next         = lnk_reg;
    lnk_next.rst_s1  = srst;
    lnk_next.rst_s2  = lnk_reg.rst_s1;
    lnk_next.ce_s1   = ce;
    lnk_next.ce_s2   = lnk_reg.ce_s1;
    lnk_next.drdy_s1 = drdy_n;
    lnk_next.drdy_s2 = lnk_reg.drdy_s1;
    lnk_next.drdy_s3 = lnk_reg.drdy_s2;
    lnk_next.miso_s1 = miso;
    lnk_next.miso_s2 = lnk_reg.miso_s1;
    lnk_next.ack_s1  = pk_reg.ack;
    lnk_next.ack_s2  = lnk_reg.ack_s1;
    if (lnk_reg.rst_s2) begin
      lnk_next.state   = LNK_IDLE;
      lnk_next.div     = '0;
      lnk_next.bitcnt  = '0;
      lnk_next.sclk    = 1'b1;
      lnk_next.cs_n    = 1'b1;
      lnk_next.shreg   = '0;
      lnk_next.hold    = '0;
      lnk_next.req     = 1'b0;
      lnk_next.overrun = 1'b0;
    end else if (lnk_reg.ce_s2) begin
      case (lnk_reg.state)
        LNK_IDLE: begin
          if (drdy_fall) begin
            lnk_next.state  = LNK_SHIFT;
            lnk_next.cs_n   = 1'b0;
            lnk_next.div    = '0;
            lnk_next.bitcnt = '0;
          end
        end
        LNK_SHIFT: begin
          if (lnk_reg.div == 8'(SCLK_HALF - 1)) begin
            lnk_next.div  = '0;
            lnk_next.sclk = !lnk_reg.sclk;
            if (!lnk_reg.sclk) begin
              for (int b = 0; b < `SGC_BUNDLES; b++) begin
                lnk_next.shreg[b] = {lnk_reg.shreg[b][`SGC_CHAIN_BITS-2:0], lnk_reg.miso_s2[b]};
              end
              lnk_next.bitcnt = lnk_reg.bitcnt + 8'h01;
              if (lnk_reg.bitcnt == 8'(`SGC_CHAIN_BITS - 1)) begin
                lnk_next.state = LNK_DONE;
              end
            end
          end else begin
            lnk_next.div = lnk_reg.div + 8'h01;
          end
        end
        LNK_DONE: begin
          lnk_next.cs_n  = 1'b1;
          lnk_next.state = LNK_IDLE;
          if (lnk_reg.req == lnk_reg.ack_s2) begin
            lnk_next.hold = lnk_reg.shreg;
            lnk_next.req  = !lnk_reg.req;
          end else begin
            lnk_next.overrun = 1'b1;
          end
        end
        default: lnk_next.state = LNK_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    lnk_reg <= lnk_next;
  end

  // Hold bank is stable while a handshake is open
  generate
    for (genvar c = 0; c < `SGC_CHANS; c++) begin : g_samp
      assign samp[c] = lnk_reg.hold[c / `SGC_CHAIN]
                       [`SGC_CHAIN_BITS-1-(c % `SGC_CHAIN)*`SGC_SAMPLE_W -: `SGC_SAMPLE_W];
    end
  endgenerate

  assign ext  = {{(`SGC_EXT_W-`SGC_SAMPLE_W){samp[pk_reg.idx][`SGC_SAMPLE_W-1]}}, samp[pk_reg.idx]};
  assign rest = pk_reg.mask >> ({1'b0, pk_reg.idx} + 6'h1);

  // System side: masking and packing
  always_comb begin
    pk_next        = pk_reg;
    pk_next.req_s1 = lnk_reg.req;
    pk_next.req_s2 = pk_reg.req_s1;
    fifo_wr_valid  = 1'b0;
    fifo_wr_data   = '0;
    if (srst) begin
      pk_next = '0;
      pk_next.state = PK_IDLE;
    end else if (ce) begin
      case (pk_reg.state)
        PK_IDLE: begin
          if (pk_reg.req_s2 != pk_reg.ack) begin
            pk_next.state = PK_HDR;
            pk_next.mask  = chan_mask;
          end
        end
        PK_HDR: begin
          fifo_wr_valid     = 1'b1;
          fifo_wr_data.data = pk_reg.seq;
          fifo_wr_data.last = (pk_reg.mask == '0);
          if (fifo_wr_ready) begin
            pk_next.seq  = pk_reg.seq + 16'h0001;
            pk_next.idx  = '0;
            pk_next.half = 1'b0;
            if (pk_reg.mask == '0) begin
              pk_next.ack   = !pk_reg.ack;
              pk_next.state = PK_IDLE;
            end else begin
              pk_next.state = PK_WORD;
            end
          end
        end
        PK_WORD: begin
          if (!pk_reg.mask[pk_reg.idx]) begin
            pk_next.idx = pk_reg.idx + 5'h01;
          end else begin
            fifo_wr_valid     = 1'b1;
            fifo_wr_data.data = pk_reg.half ? ext[`SGC_WORD_W-1:0] : ext[`SGC_EXT_W-1:`SGC_WORD_W];
            fifo_wr_data.last = pk_reg.half && (rest == '0);
            if (fifo_wr_ready) begin
              pk_next.half = !pk_reg.half;
              if (pk_reg.half) begin
                pk_next.idx = pk_reg.idx + 5'h01;
                if (rest == '0) begin
                  pk_next.ack   = !pk_reg.ack;
                  pk_next.state = PK_IDLE;
                end
              end
            end
          end
        end
        default: pk_next.state = PK_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    pk_reg <= pk_next;
  end

  sgc_fifo #(
    .W     (`SGC_FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (ref_clk),
    .rst      (srst),
    .ce       (ce),
    .wr_valid (fifo_wr_valid),
    .wr_data  (fifo_wr_data),
    .wr_ready (fifo_wr_ready),
    .rd_valid (pkt_valid),
    .rd_data  (pkt_data),
    .rd_ready (pkt_ready)
  );

  // Checks on the link side
  property p_fall_starts;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    (lnk_reg.ce_s2 && lnk_reg.state == LNK_IDLE && drdy_fall) |=> (lnk_reg.state == LNK_SHIFT && !cs_n);
  endproperty
  a_fall_starts: assert property (p_fall_starts) else $error("read did not start on data-ready fall");

  property p_wait_forever;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    (lnk_reg.state == LNK_IDLE && !drdy_fall) |=> (lnk_reg.state == LNK_IDLE && cs_n);
  endproperty
  a_wait_forever: assert property (p_wait_forever) else $error("left idle without data-ready");

  property p_full_chain;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    (lnk_reg.state == LNK_DONE && $past(lnk_reg.ce_s2))
      |-> (lnk_reg.bitcnt == 8'(`SGC_CHAIN_BITS) && $past(lnk_reg.state) == LNK_SHIFT);
  endproperty
  a_full_chain: assert property (p_full_chain) else $error("chain read not 144 bits");

  property p_sclk_rate;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    $changed(sclk) |-> ($past(lnk_reg.div) == 8'(SCLK_HALF - 1) && $past(lnk_reg.state) == LNK_SHIFT);
  endproperty
  a_sclk_rate: assert property (p_sclk_rate) else $error("serial clock edge off its divider");

  property p_slot_one;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    $fell(cs_n) |-> $past(lnk_reg.drdy_s3) && !$past(lnk_reg.drdy_s2);
  endproperty
  a_slot_one: assert property (p_slot_one) else $error("read began without slot one data-ready");

  property p_hold_stable;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    (lnk_reg.req != lnk_reg.ack_s2) |=> $stable(lnk_reg.hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("sample bank changed during handover");

  property p_div_range;
    @(posedge link_clk) disable iff (lnk_reg.rst_s2)
    (lnk_reg.state == LNK_SHIFT) |-> (lnk_reg.div <= 8'(SCLK_HALF - 1));
  endproperty
  a_div_range: assert property (p_div_range) else $error("serial clock divider out of range");

  // Checks on the system side
  property p_sign_ext;
    @(posedge ref_clk) disable iff (srst)
    (fifo_wr_valid && pk_reg.state == PK_WORD && !pk_reg.half)
      |-> fifo_wr_data.data[15:8] == {8{fifo_wr_data.data[7]}};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("upper word not sign-extended");

  property p_mask_only;
    @(posedge ref_clk) disable iff (srst)
    (fifo_wr_valid && pk_reg.state == PK_WORD) |-> pk_reg.mask[pk_reg.idx];
  endproperty
  a_mask_only: assert property (p_mask_only) else $error("masked channel written");

  property p_last_closes;
    @(posedge ref_clk) disable iff (srst)
    (ce && fifo_wr_valid && fifo_wr_ready && fifo_wr_data.last) |=> (pk_reg.state == PK_IDLE && $changed(pk_reg.ack));
  endproperty
  a_last_closes: assert property (p_last_closes) else $error("end-of-set word did not close set");

  property p_out_hold;
    @(posedge ref_clk) disable iff (srst)
    (pkt_valid && !pkt_ready) |=> (pkt_valid && $stable(pkt_data));
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output word dropped under stall");

  property p_set_order;
    @(posedge ref_clk) disable iff (srst)
    (ce && pk_reg.state == PK_IDLE && pk_reg.req_s2 != pk_reg.ack) |=> (pk_reg.state == PK_HDR);
  endproperty
  a_set_order: assert property (p_set_order) else $error("new set did not start with its header");

  property p_ce_freeze;
    @(posedge ref_clk) disable iff (srst)
    !ce |=> ($stable(pk_reg.state) && $stable(pkt_valid) && $stable(pkt_data));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("packer or output moved while disabled");

  c_read_start: cover property (@(posedge link_clk) disable iff (lnk_reg.rst_s2) $fell(cs_n));
  c_set_end:    cover property (@(posedge ref_clk) disable iff (srst) fifo_wr_valid && fifo_wr_data.last);
  c_fifo_full:  cover property (@(posedge ref_clk) disable iff (srst) !fifo_wr_ready);
  c_overrun:    cover property (@(posedge link_clk) disable iff (lnk_reg.rst_s2) $rose(overrun));
endmodule // sgc_sample_gatherer

/* File: sgc_sample_gatherer_test.sv */
// Testbench for the sample gatherer: converter chains, masking, packet drain with stalls.
// Assumes sgc_pkg, sgc_fifo, sgc_sample_gatherer and sgc_adc_model compiled before it.
`timescale 1ns/1ps
module sgc_sample_gatherer_test;
  import sgc_pkg::*;
  logic                          ref_clk   = 1'b0;
  logic                          link_clk  = 1'b0;
  logic                          srst      = 1'b1;
  logic                          ce        = 1'b1;
  logic                          pkt_ready = 1'b0;
  logic                          start     = 1'b0;
  logic [`SGC_CHANS-1:0]         chan_mask = '1;
  sgc_chain_t [`SGC_BUNDLES-1:0] load      = '0;
  logic                          drdy_n, sclk, cs_n, overrun, pkt_valid;
  logic [`SGC_FIFO_W-1:0]        pkt_data;
  logic [`SGC_BUNDLES-1:0]       miso;
  int                            bad_count = 0;
  int                            n_checks  = 0;
  int                            nrise     = 0;

  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge sclk) if (cs_n === 1'b0) nrise = nrise + 1;

  sgc_sample_gatherer #(.FIFO_DEPTH(16)) sgc_sample_gatherer_inst (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .link_clk(link_clk), .chan_mask(chan_mask),
    .drdy_n(drdy_n), .miso(miso), .sclk(sclk), .cs_n(cs_n), .overrun(overrun),
    .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready));
  sgc_adc_model sgc_adc_model_inst (
    .sclk(sclk), .cs_n(cs_n), .start(start), .load(load), .drdy_n(drdy_n), .miso(miso));

  task automatic chk(input logic [`SGC_FIFO_W-1:0] got, input logic [`SGC_FIFO_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] smp(int s, int b, int k);
    return {k[0], s[2:0], b[3:0], k[3:0], 12'h5A3};
  endfunction

  // One conversion: load chains, drop data-ready, wait for the read to end
  task automatic fire(input int s);
    int n0;
    for (int b = 0; b < `SGC_BUNDLES; b++)
      for (int k = 0; k < `SGC_CHAIN; k++) load[b][143-24*k -: 24] = smp(s, b, k);
    n0 = nrise;
    @(posedge ref_clk) #1 start = 1'b1;
    @(posedge ref_clk) #1 start = 1'b0;
    for (int i = 0; i < 200 && cs_n !== 1'b0; i++) @(posedge ref_clk);
    for (int i = 0; i < 4000 && cs_n !== 1'b1; i++) @(posedge ref_clk);
    #1 chk(17'(nrise - n0), 17'h0_0090);
  endtask

  // Take one word, stalling gap+1 cycles first
  task automatic take(input logic [`SGC_FIFO_W-1:0] exp, input int gap);
    for (int i = 0; i < 3000 && pkt_valid !== 1'b1; i++) @(posedge ref_clk) #1;
    repeat (gap + 1) @(posedge ref_clk) #1;
    chk({pkt_valid, 16'h0000}, 17'h1_0000);
    chk(pkt_data, exp);
    pkt_ready = 1'b1;
    @(posedge ref_clk) #1 pkt_ready = 1'b0;
  endtask

  task automatic expect_set(input int s, input int gap);
    logic [23:0] w;
    int          hi;
    hi = -1;
    for (int c = 0; c < `SGC_CHANS; c++) if (chan_mask[c]) hi = c;
    take({hi < 0, 16'(s)}, gap);
    for (int c = 0; c < `SGC_CHANS; c++) if (chan_mask[c]) begin
      w = smp(s, c / 6, c % 6);
      take({1'b0, {8{w[23]}}, w[23:16]}, gap);
      take({c == hi, w[15:0]}, gap);
    end
  endtask

  task automatic s_no_drdy;
    repeat (500) @(posedge ref_clk) #1;
    chk({13'h0, cs_n, sclk, pkt_valid, overrun}, 17'h0_000C);
  endtask

  task automatic s_full_fill;
    chan_mask = '1;
    fire(0);
    expect_set(0, 3);
  endtask

  task automatic s_sparse;
    chan_mask = 24'h80_0421;
    fire(1);
    expect_set(1, 0);
  endtask

  task automatic s_empty_mask;
    chan_mask = '0;
    fire(2);
    expect_set(2, 0);
  endtask

  task automatic s_overrun;
    chan_mask = '1;
    fire(3);
    fire(4);
    repeat (10) @(posedge ref_clk) #1;
    chk({16'h0000, overrun}, 17'h0_0001);
    expect_set(3, 1);
    repeat (50) @(posedge ref_clk) #1;
    chk({16'h0000, pkt_valid}, 17'h0_0000);
  endtask

  // Clock enable low: a ready sink must not take the waiting header
  task automatic s_freeze;
    chan_mask = 24'h00_0001;
    fire(4);
    for (int i = 0; i < 3000 && pkt_valid !== 1'b1; i++) @(posedge ref_clk) #1;
    ce        = 1'b0;
    pkt_ready = 1'b1;
    repeat (8) @(posedge ref_clk) #1;
    chk({pkt_valid, 16'h0000}, 17'h1_0000);
    chk(pkt_data, 17'h0_0004);
    pkt_ready = 1'b0;
    ce        = 1'b1;
    expect_set(4, 0);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (10) @(posedge ref_clk) #1;
    s_no_drdy;
    s_full_fill;
    s_sparse;
    s_empty_mask;
    s_overrun;
    s_freeze;
    report_and_stop;
  end
endmodule // sgc_sample_gatherer_test
